// *** verilog/drc_config_top.sv ***
// Configuration logic of a two-lane-plus-clock D-PHY repeater:
// strap capture, I2C slave register file and link idle detection.
// Assumes SCL and SDA are oversampled by a much faster system clock,
// and that link_clk is a free-running LP sampling clock.
//
// Functional notes
// [R1] Sample equalizer strap level at reset release and use it.
// [R2] Host write to the equalizer register replaces the strap value.
// [R3] Three equalizer levels: low 3dB, mid 6dB, high 9dB.
// [R4] Edge strap: low 200ps, mid 150ps, high 250ps rise/fall.
// [R5] Swing from swing strap, edge rate from edge strap.
// [R6] Detect link activity; low power while link in ULPS or LP.
// [R7] Read-only identity registers at 00h and 01h.
// [R8] Register 02h: equalizer code bits 3:0, upper bits zero.
// [R9] Register 03h: edge-rate code bits 2:0, upper bits zero.
// [R10] Register 04h reserved, reads fixed pattern only.
// [R11] Register 05h: pre-emphasis bits 3:2, swing bits 1:0.
// [R12] Write: address with write bit, sub-address, then data.
// [R13] Read: write sub-address, repeated start, address with read bit.
// [R14] Respond to seven-bit slave address 1101100; LSB is read/write.
`timescale 1ns/10ps
module drc_config_top (
  // System clock and reset
  input  wire logic              clock,
  input  wire logic              chip_reset_low,
  // Serial link pins, shared with equalizer and edge straps
  input  wire logic              equalizer_strap_clock_pin,
  input  wire logic              edge_strap_data_pin_i,
  output logic                   edge_strap_data_pin_o,
  output logic                   edge_strap_data_pin_oe,
  // Resolved strap levels
  input  drc_pkg::drc_strap_t    strap_level,
  // D-PHY LP receiver outputs, sampled on link_clk
  input  wire logic              link_clk,
  input  wire logic [2:0]        lane_lp_p,
  input  wire logic [2:0]        lane_lp_n,
  // Settings to the analog path
  output drc_pkg::drc_cfg_t      active_cfg,
  output logic                   low_power
);

  // Link domain

  typedef struct packed {
    logic [2:0] prev_p;
    logic [2:0] prev_n;
    logic [2:0] hs;
    logic       active;
  } drc_link_st_t;

  drc_link_st_t l_ff;
  drc_link_st_t nxt_l;
  logic [5:0]   lane_s;
  logic         link_chip_reset_low_s;

  drc_sync2 #(.W(6)) u_lane_sync (
    .clock (link_clk),
    .din   ({lane_lp_p, lane_lp_n}),
    .dout  (lane_s)
  );

  drc_sync2 #(.W(1)) u_link_rst_sync (
    .clock (link_clk),
    .din   (chip_reset_low),
    .dout  (link_chip_reset_low_s)
  );

  // [R6] HS entry detection
  // LP-01 then LP-00 is a high-speed request; LP-10 then LP-00 is
  // escape (ULPS among them) and LP-11 is stop, both count as idle.
  always_comb begin
    nxt_l        = l_ff;
    nxt_l.prev_p = lane_s[5:3];
    nxt_l.prev_n = lane_s[2:0];
    for (int i = 0; i < drc_pkg::LANES; i++) begin
      if (lane_s[3+i] && lane_s[i]) begin
        nxt_l.hs[i] = 1'b0;
      end else if (!lane_s[3+i] && !lane_s[i]
                   && !l_ff.prev_p[i] && l_ff.prev_n[i]) begin
        nxt_l.hs[i] = 1'b1;
      end
    end
    nxt_l.active = |l_ff.hs;
  end

  always_ff @(posedge link_clk) begin
    if (!link_chip_reset_low_s) begin
      l_ff <= '{prev_p: 3'h7, prev_n: 3'h7, hs: 3'h0, active: 1'b0};
    end else begin
      l_ff <= nxt_l;
    end
  end

  // System domain

  typedef struct packed {
    drc_pkg::drc_i2c_st_t st;
    logic                 scl_d;
    logic                 sda_d;
    logic [3:0]           bitcnt;
    logic [7:0]           shift;
    logic [7:0]           tx;
    logic                 rw;
    logic [7:0]           sub;
    logic                 nack;
    logic                 sda_oe;
    logic                 sda_o;
    drc_pkg::drc_cfg_t    cfg;
    logic                 strap_done;
    logic                 low_power;
  } drc_main_st_t;

  drc_main_st_t        s_ff;
  drc_main_st_t        nxt_s;
  logic                scl_s;
  logic                sda_s;
  logic                active_s;
  drc_pkg::drc_strap_t strap_s;

  drc_sync2 #(.W(2)) u_pin_sync (
    .clock (clock),
    .din   ({equalizer_strap_clock_pin, edge_strap_data_pin_i}),
    .dout  ({scl_s, sda_s})
  );

  drc_sync2 #(.W(6)) u_strap_sync (
    .clock (clock),
    .din   (strap_level),
    .dout  (strap_s)
  );

  drc_sync2 #(.W(1)) u_active_sync (
    .clock (clock),
    .din   (l_ff.active),
    .dout  (active_s)
  );

  // [R7] Register read mux
  function automatic logic [7:0] reg_read(input logic [7:0] ofs,
                                          input drc_pkg::drc_cfg_t c);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      drc_pkg::OFS_DEV_ID: v = drc_pkg::DEV_ID_VALUE;
      drc_pkg::OFS_REV_ID: v = drc_pkg::REV_ID_VALUE;
      // [R8] Equalizer readback
      drc_pkg::OFS_EQ:     v = {drc_pkg::EQ_RSVD_VAL, c.eq};
      // [R9] Edge rate readback
      drc_pkg::OFS_ERC:    v = {drc_pkg::ERC_RSVD_VAL, c.edge_rate_setting};
      // [R10] Fixed pattern
      drc_pkg::OFS_RSVD:   v = drc_pkg::RSVD_FIXED_VAL;
      // [R11] Emphasis and swing readback
      drc_pkg::OFS_EMPH:   v = {drc_pkg::EMPH_RSVD_VAL, c.pre, c.swing};
      default:             v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // [R3] Equalizer strap map
  function automatic logic [3:0] eq_map(input drc_pkg::drc_level_t l);
    logic [3:0] c;
    case (l)
      drc_pkg::LVL_LOW: c = drc_pkg::EQ_CODE_3DB;
      drc_pkg::LVL_MID: c = drc_pkg::EQ_CODE_6DB;
      default:          c = drc_pkg::EQ_CODE_9DB;
    endcase
    return c;
  endfunction : eq_map

  // [R4] Edge strap map
  function automatic logic [2:0] erc_map(input drc_pkg::drc_level_t l);
    logic [2:0] c;
    case (l)
      drc_pkg::LVL_LOW: c = drc_pkg::ERC_CODE_200PS;
      drc_pkg::LVL_MID: c = drc_pkg::ERC_CODE_150PS;
      default:          c = drc_pkg::ERC_CODE_250PS;
    endcase
    return c;
  endfunction : erc_map

  function automatic logic [1:0] swing_map(input drc_pkg::drc_level_t l);
    logic [1:0] c;
    case (l)
      drc_pkg::LVL_LOW: c = drc_pkg::SWING_CODE_LOW;
      drc_pkg::LVL_MID: c = drc_pkg::SWING_CODE_MID;
      default:          c = drc_pkg::SWING_CODE_HIGH;
    endcase
    return c;
  endfunction : swing_map

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] rd_now;
  logic [7:0] rd_next;
  logic [7:0] sub_inc;

  // Edges are taken from the synchronised copies only
  assign scl_rise   = scl_s && !s_ff.scl_d;
  assign scl_fall   = !scl_s && s_ff.scl_d;
  assign start_cond = scl_s && s_ff.scl_d && !sda_s && s_ff.sda_d;
  assign stop_cond  = scl_s && s_ff.scl_d && sda_s && !s_ff.sda_d;
  assign sub_inc    = s_ff.sub + 8'h01;
  assign rd_now     = reg_read(s_ff.sub, s_ff.cfg);
  assign rd_next    = reg_read(sub_inc, s_ff.cfg);

  always_comb begin
    nxt_s           = s_ff;
    nxt_s.scl_d     = scl_s;
    nxt_s.sda_d     = sda_s;
    nxt_s.sda_o     = 1'b0;
    // [R6] Low power while the link idles
    nxt_s.low_power = !active_s;

    if (start_cond) begin
      // [R13] Start or repeated start restarts address phase
      nxt_s.st     = drc_pkg::ST_ADDR;
      nxt_s.bitcnt = 4'h0;
      nxt_s.sda_oe = 1'b0;
    end else if (stop_cond) begin
      nxt_s.st     = drc_pkg::ST_IDLE;
      nxt_s.sda_oe = 1'b0;
    end else begin
      case (s_ff.st)
        drc_pkg::ST_ADDR, drc_pkg::ST_SUB, drc_pkg::ST_WDATA: begin
          if (scl_rise) begin
            nxt_s.shift  = {s_ff.shift[6:0], sda_s};
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
          end else if (scl_fall && s_ff.bitcnt == drc_pkg::BITS_PER_BYTE) begin
            nxt_s.bitcnt = 4'h0;
            nxt_s.sda_oe = 1'b1;
            if (s_ff.st == drc_pkg::ST_ADDR) begin
              // [R14] Address match, LSB is direction
              if (s_ff.shift[7:1] == drc_pkg::I2C_SLAVE_ADDR) begin
                nxt_s.rw = s_ff.shift[0];
                nxt_s.st = drc_pkg::ST_ACK_ADDR;
              end else begin
                nxt_s.sda_oe = 1'b0;
                nxt_s.st     = drc_pkg::ST_IDLE;
              end
            end else if (s_ff.st == drc_pkg::ST_SUB) begin
              // [R12] Sub-address selects the register
              nxt_s.sub = s_ff.shift;
              nxt_s.st  = drc_pkg::ST_ACK_SUB;
            end else begin
              // [R12] Data byte stored at sub-address
              case (s_ff.sub)
                // [R2] Host equalizer overrides strap
                drc_pkg::OFS_EQ:   nxt_s.cfg.eq = s_ff.shift[drc_pkg::EQ_MSB:0];
                drc_pkg::OFS_ERC:  nxt_s.cfg.edge_rate_setting = s_ff.shift[drc_pkg::ERC_MSB:0];
                drc_pkg::OFS_EMPH: begin
                  nxt_s.cfg.pre   = s_ff.shift[drc_pkg::PRE_MSB:drc_pkg::PRE_LSB];
                  nxt_s.cfg.swing = s_ff.shift[drc_pkg::SWING_MSB:0];
                end
                default: nxt_s.cfg = s_ff.cfg;
              endcase
              nxt_s.sub = sub_inc;
              nxt_s.st  = drc_pkg::ST_ACK_WDATA;
            end
          end
        end

        drc_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (s_ff.rw) begin
              // [R13] Return the selected register
              nxt_s.tx     = rd_now;
              nxt_s.sda_oe = !rd_now[7];
              nxt_s.st     = drc_pkg::ST_RDATA;
            end else begin
              nxt_s.sda_oe = 1'b0;
              nxt_s.st     = drc_pkg::ST_SUB;
            end
          end
        end

        drc_pkg::ST_ACK_SUB, drc_pkg::ST_ACK_WDATA: begin
          if (scl_fall) begin
            nxt_s.sda_oe = 1'b0;
            nxt_s.st     = drc_pkg::ST_WDATA;
          end
        end

        drc_pkg::ST_RDATA: begin
          if (scl_rise) begin
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (s_ff.bitcnt == drc_pkg::BITS_PER_BYTE) begin
              nxt_s.bitcnt = 4'h0;
              nxt_s.sda_oe = 1'b0;
              nxt_s.st     = drc_pkg::ST_RACK;
            end else begin
              nxt_s.tx     = {s_ff.tx[6:0], 1'b0};
              nxt_s.sda_oe = !s_ff.tx[6];
            end
          end
        end

        drc_pkg::ST_RACK: begin
          if (scl_rise) begin
            nxt_s.nack = sda_s;
          end else if (scl_fall) begin
            if (!s_ff.nack) begin
              // Host acked: stream the next register
              nxt_s.sub    = sub_inc;
              nxt_s.tx     = rd_next;
              nxt_s.sda_oe = !rd_next[7];
              nxt_s.st     = drc_pkg::ST_RDATA;
            end else begin
              nxt_s.st = drc_pkg::ST_IDLE;
            end
          end
        end

        drc_pkg::ST_IDLE: nxt_s.sda_oe = 1'b0;

        default: begin
          nxt_s.st     = drc_pkg::ST_IDLE;
          nxt_s.sda_oe = 1'b0;
        end
      endcase
    end

    // [R1] Straps caught once, first cycle after release
    // The link cannot deliver a write this early, so no conflict.
    if (!s_ff.strap_done) begin
      nxt_s.strap_done = 1'b1;
      nxt_s.cfg.eq     = eq_map(strap_s.eq);
      // [R5] Edge and swing from straps
      nxt_s.cfg.edge_rate_setting    = erc_map(strap_s.edge_rate_setting);
      nxt_s.cfg.swing  = swing_map(strap_s.swing);
    end
  end

  always_ff @(posedge clock) begin
    if (!chip_reset_low) begin
      s_ff <= '{st: drc_pkg::ST_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                bitcnt: 4'h0, shift: 8'h00, tx: 8'h00, rw: 1'b0,
                sub: drc_pkg::OFS_DEV_ID, nack: 1'b0, sda_oe: 1'b0,
                sda_o: 1'b0, cfg: drc_pkg::CFG_RST,
                strap_done: 1'b0, low_power: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign edge_strap_data_pin_o  = s_ff.sda_o;
  assign edge_strap_data_pin_oe = s_ff.sda_oe;
  assign active_cfg             = s_ff.cfg;
  assign low_power              = s_ff.low_power;

endmodule : drc_config_top

// *** verilog/drc_pkg.sv ***
// Shared constants and types of the repeater configuration block.
// Assumes strap levels arrive already resolved to low, mid or high.
package drc_pkg;

  // Slave address on the configuration link
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h6c;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // Register offsets
  localparam logic [7:0] OFS_DEV_ID = 8'h00;
  localparam logic [7:0] OFS_REV_ID = 8'h01;
  localparam logic [7:0] OFS_EQ     = 8'h02;
  localparam logic [7:0] OFS_ERC    = 8'h03;
  localparam logic [7:0] OFS_RSVD   = 8'h04;
  localparam logic [7:0] OFS_EMPH   = 8'h05;

  // Identity values, arbitrary
  localparam logic [7:0] DEV_ID_VALUE = 8'ha5;
  localparam logic [7:0] REV_ID_VALUE = 8'h11;

  // Reserved field values
  localparam logic [3:0] EQ_RSVD_VAL    = 4'h0;
  localparam logic [4:0] ERC_RSVD_VAL   = 5'h00;
  localparam logic [7:0] RSVD_FIXED_VAL = 8'h08;
  localparam logic [3:0] EMPH_RSVD_VAL  = 4'h6;

  // Field positions
  localparam int EQ_MSB    = 3;
  localparam int ERC_MSB   = 2;
  localparam int PRE_MSB   = 3;
  localparam int PRE_LSB   = 2;
  localparam int SWING_MSB = 1;

  // Equalizer codes
  localparam logic [3:0] EQ_CODE_3DB = 4'h2;
  localparam logic [3:0] EQ_CODE_6DB = 4'h6;
  localparam logic [3:0] EQ_CODE_9DB = 4'hb;

  // Edge rate codes
  localparam logic [2:0] ERC_CODE_250PS = 3'h1;
  localparam logic [2:0] ERC_CODE_200PS = 3'h3;
  localparam logic [2:0] ERC_CODE_150PS = 3'h7;

  // Swing codes chosen by the swing strap
  localparam logic [1:0] SWING_CODE_LOW  = 2'h0;
  localparam logic [1:0] SWING_CODE_MID  = 2'h1;
  localparam logic [1:0] SWING_CODE_HIGH = 2'h3;

  localparam int LANES = 3;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } drc_level_t;

  typedef struct packed {
    drc_level_t eq;
    drc_level_t edge_rate_setting;
    drc_level_t swing;
  } drc_strap_t;

  typedef struct packed {
    logic [3:0] eq;
    logic [2:0] edge_rate_setting;
    logic [1:0] pre;
    logic [1:0] swing;
  } drc_cfg_t;

  localparam drc_cfg_t CFG_RST = '{eq: 4'h0, edge_rate_setting: 3'h0, pre: 2'h0, swing: 2'h0};

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
  } drc_i2c_st_t;

endpackage : drc_pkg

// *** verilog/drc_sync2.sv ***
// Two-flop synchroniser for a group of levels.
// Assumes each bit is an independent level; no reset, data only.
`timescale 1ns/10ps
module drc_sync2 #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clock,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } drc_sync_st_t;

  drc_sync_st_t s_ff;
  drc_sync_st_t nxt_s;

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.meta   = din;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge clock) begin
    s_ff <= nxt_s;
  end

  assign dout = s_ff.stable;

endmodule : drc_sync2

// *** bench/drc_config_sva.sv ***
// Port checker for the repeater configuration block.
// Assumes straps stay put around reset release and lanes idle at 11.
`timescale 1ns/10ps
module drc_config_sva (
  // Clock and reset
  input wire logic                clock,
  input wire logic                chip_reset_low,
  // Serial link
  input wire logic                equalizer_strap_clock_pin,
  input wire logic                edge_strap_data_pin_o,
  input wire logic                edge_strap_data_pin_oe,
  // Straps and link lanes
  input wire drc_pkg::drc_strap_t strap_level,
  input wire logic [2:0]          lane_lp_p,
  input wire logic [2:0]          lane_lp_n,
  // Results
  input wire drc_pkg::drc_cfg_t   active_cfg,
  input wire logic                low_power
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!chip_reset_low);

  rst_release_a: assert property ($rose(chip_reset_low) |-> low_power && !edge_strap_data_pin_oe)
    else $error("outputs not in reset state at release");
  strap_eq_a: assert property ($rose(chip_reset_low) |=> active_cfg.eq == (strap_level.eq == drc_pkg::LVL_LOW ? 4'h2 :
    strap_level.eq == drc_pkg::LVL_MID ? 4'h6 : 4'hb)) else $error("equalizer strap not applied");
  strap_erc_a: assert property ($rose(chip_reset_low) |=> active_cfg.edge_rate_setting == (strap_level.edge_rate_setting == drc_pkg::LVL_LOW ? 3'h3 :
    strap_level.edge_rate_setting == drc_pkg::LVL_MID ? 3'h7 : 3'h1)) else $error("edge strap not applied");
  strap_swing_a: assert property ($rose(chip_reset_low) |=> active_cfg.pre == 2'h0 && active_cfg.swing ==
    (strap_level.swing == drc_pkg::LVL_LOW ? 2'h0 : strap_level.swing == drc_pkg::LVL_MID ? 2'h1 : 2'h3))
    else $error("swing strap not applied");
  // A setting moves only at strap capture or with the ack of a data byte
  cfg_write_a: assert property ($changed(active_cfg) |-> !$past(chip_reset_low, 2) || $rose(edge_strap_data_pin_oe))
    else $error("settings changed without a write");
  oe_open_a: assert property (edge_strap_data_pin_oe |-> !edge_strap_data_pin_o)
    else $error("data line driven high");
  oe_scl_low_a: assert property ($changed(edge_strap_data_pin_oe) |-> !equalizer_strap_clock_pin)
    else $error("data drive moved while clock high");
  ack_hold_a: assert property ($rose(edge_strap_data_pin_oe) |=> edge_strap_data_pin_oe [*4])
    else $error("data drive too short");
  idle_lp_a: assert property ($rose(&{lane_lp_p, lane_lp_n}) |-> ##[1:200] low_power)
    else $error("no low power after link stop");
  // LP-01 then LP-00 on all lanes is a high-speed request and must leave low power
  busy_lp_a: assert property ($fell(|{lane_lp_p, lane_lp_n}) && $past({lane_lp_p, lane_lp_n}) == 6'h07 |-> ##[1:200] !low_power)
    else $error("still low power in high speed");
endmodule : drc_config_sva

bind drc_config_top drc_config_sva i_drc_config_sva (
  .clock(clock), .chip_reset_low(chip_reset_low), .equalizer_strap_clock_pin(equalizer_strap_clock_pin),
  .edge_strap_data_pin_o(edge_strap_data_pin_o), .edge_strap_data_pin_oe(edge_strap_data_pin_oe),
  .strap_level(strap_level), .lane_lp_p(lane_lp_p), .lane_lp_n(lane_lp_n),
  .active_cfg(active_cfg), .low_power(low_power)
);

// *** bench/drc_i2c_host.sv ***
// Host controller model: bit-level master of the configuration link.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module drc_i2c_host #(
  parameter int HALF = 10
) (
  // Bench clock
  input wire logic clock,
  // Data wire level and host drive
  input wire logic sda,
  output logic     scl,
  output logic     sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Bit time far faster than a real bus, to keep runs short
  task automatic pause(input int n);
    repeat (n * HALF) @(negedge clock);
  endtask : pause

  task automatic start;
    pause(1);
    sda_pull = 1'b0;
    pause(1);
    scl = 1'b1;
    pause(1);
    sda_pull = 1'b1;
    pause(1);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    pause(1);
    sda_pull = 1'b1;
    pause(1);
    scl = 1'b1;
    pause(1);
    sda_pull = 1'b0;
    pause(1);
  endtask : stop

  // byte msb first, data moved only with clock low
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_seen);
    logic [8:0] bits;
    bits = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      pause(1);
      sda_pull = ~bits[i];
      pause(1);
      scl = 1'b1;
      pause(2);
      bits[i] = sda;
      scl = 1'b0;
    end
    q = bits[8:1];
    ack_seen = bits[0];
  endtask : xbyte
endmodule : drc_i2c_host

// *** bench/drc_config_top_tb.sv ***
// Self-checking bench of the repeater configuration block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/10ps
module drc_config_top_tb;
  logic                clock = 1'b0;
  logic                chip_reset_low = 1'b0;
  logic                link_clk = 1'b0;
  logic [2:0]          lane_lp_p = 3'h7;
  logic [2:0]          lane_lp_n = 3'h7;
  drc_pkg::drc_strap_t strap_level = '{eq: drc_pkg::LVL_LOW, edge_rate_setting: drc_pkg::LVL_LOW, swing: drc_pkg::LVL_LOW};
  drc_pkg::drc_cfg_t   active_cfg;
  logic                low_power, scl, sda, sda_pull, sda_o, sda_oe, nak;
  logic [7:0]          q;
  int                  fails = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  // strap codes for low, mid, high
  logic [3:0]          eq_exp[3] = '{4'h2, 4'h6, 4'hb};
  logic [2:0]          erc_exp[3] = '{3'h3, 3'h7, 3'h1};
  logic [1:0]          sw_exp[3] = '{2'h0, 2'h1, 2'h3};

  assign sda = ~(sda_pull | (sda_oe & ~sda_o));
  always #4 clock = ~clock;
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end

  drc_config_top i_drc_config_top (
    .clock(clock), .chip_reset_low(chip_reset_low), .equalizer_strap_clock_pin(scl), .edge_strap_data_pin_i(sda),
    .edge_strap_data_pin_o(sda_o), .edge_strap_data_pin_oe(sda_oe), .strap_level(strap_level),
    .link_clk(link_clk), .lane_lp_p(lane_lp_p), .lane_lp_n(lane_lp_n),
    .active_cfg(active_cfg), .low_power(low_power)
  );
  drc_i2c_host i_drc_i2c_host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input int hold, input drc_pkg::drc_level_t lvl);
    @(negedge clock);
    chip_reset_low = 1'b0;
    strap_level = '{eq: lvl, edge_rate_setting: lvl, swing: lvl};
    repeat (hold) @(negedge clock);
    check("low power in reset", {15'h0, low_power}, 16'h1);
    chip_reset_low = 1'b1;
    repeat (4) @(negedge clock);
  endtask : do_reset

  task automatic open_at(input logic [7:0] sub);
    i_drc_i2c_host.start;
    i_drc_i2c_host.xbyte(8'hd8, 1'b1, q, nak);
    check("address ack", {15'h0, nak}, 16'h0);
    i_drc_i2c_host.xbyte(sub, 1'b1, q, nak);
    check("sub ack", {15'h0, nak}, 16'h0);
  endtask : open_at

  task automatic reg_write(input logic [7:0] sub, input logic [7:0] d[$]);
    open_at(sub);
    foreach (d[i]) begin
      i_drc_i2c_host.xbyte(d[i], 1'b1, q, nak);
      check("data ack", {15'h0, nak}, 16'h0);
    end
    i_drc_i2c_host.stop;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] sub, input logic [7:0] exp[$]);
    open_at(sub);
    i_drc_i2c_host.start;
    i_drc_i2c_host.xbyte(8'hd9, 1'b1, q, nak);
    check("read address ack", {15'h0, nak}, 16'h0);
    foreach (exp[i]) begin
      i_drc_i2c_host.xbyte(8'hff, i == exp.size() - 1, q, nak);
      check("read data", {8'h0, q}, {8'h0, exp[i]});
    end
    i_drc_i2c_host.stop;
  endtask : reg_read

  initial begin
    for (int k = 0; k < 3; k++) begin
      do_reset(k == 0 ? 16 : 64, drc_pkg::drc_level_t'(k));
      check("eq strap", {12'h0, active_cfg.eq}, {12'h0, eq_exp[k]});
      check("edge strap", {13'h0, active_cfg.edge_rate_setting}, {13'h0, erc_exp[k]});
      check("swing strap", {14'h0, active_cfg.swing}, {14'h0, sw_exp[k]});
    end
    reg_read(8'h00, {drc_pkg::DEV_ID_VALUE, drc_pkg::REV_ID_VALUE, 8'h0b, 8'h01, 8'h08, 8'h63});
    // Reserved bits written as ones must not stick; 04h ignores the write
    reg_write(8'h02, {8'hf6, 8'hff, 8'h55, 8'h0d});
    check("settings", {5'h0, active_cfg}, {5'h0, 4'h6, 3'h7, 2'h3, 2'h1});
    reg_write(8'h00, {8'h00, 8'h00});
    reg_read(8'h00, {drc_pkg::DEV_ID_VALUE, drc_pkg::REV_ID_VALUE, 8'h06, 8'h07, 8'h08, 8'h6d});
    i_drc_i2c_host.start;
    i_drc_i2c_host.xbyte(8'hda, 1'b1, q, nak);
    check("foreign address", {15'h0, nak}, 16'h1);
    i_drc_i2c_host.stop;
    lane_lp_p = 3'h0;
    repeat (40) @(negedge clock);
    lane_lp_n = 3'h0;
    for (int i = 0; i < 300 && low_power !== 1'b0; i++) @(negedge clock);
    check("active link", {15'h0, low_power}, 16'h0);
    lane_lp_p = 3'h7;
    lane_lp_n = 3'h7;
    for (int i = 0; i < 300 && low_power !== 1'b1; i++) @(negedge clock);
    check("idle link", {15'h0, low_power}, 16'h1);
    // Escape entry, LP-10 then LP-00, must not count as activity
    lane_lp_n = 3'h0;
    repeat (40) @(negedge clock);
    lane_lp_p = 3'h0;
    repeat (200) @(negedge clock);
    check("escape idle", {15'h0, low_power}, 16'h1);
    lane_lp_p = 3'h7;
    lane_lp_n = 3'h7;
    repeat (4) @(negedge clock);
    tally_and_finish;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish;
    end
  end
endmodule : drc_config_top_tb
